// ==== smbtg_top.sv ====
// SMBus master bus-phase timing generator: SCL/SDA phase sequencing
// from overflow strobes, plus SCL clock-low timeout detection.
// Assumes ovf_strobe_in is a one-cycle pulse on clk_in; SCL is a pin.
`timescale 1ns/1ns
module smbtg_top #(
	parameter int TIMEOUT_CYC = smbtg_pkg::SCL_LOW_TIMEOUT_CYC
) (
	input wire logic clk_in, // System clock, 10 MHz
	input wire logic rst_in, // Async reset, active high
	input wire logic ovf_strobe_in, // Clock-source overflow pulse
	input wire logic start_in, // Request START from idle, hold until busy
	input wire logic cmd_valid_in, // Next bus command valid
	input wire logic [1:0] cmd_in, // Bit, restart or stop
	input wire logic sda_bit_in, // Data bit to drive
	input wire logic scl_in, // SCL pin level
	input wire logic sda_in, // SDA pin level
	output logic scl_out, // SCL drive value (always 0)
	output logic scl_oe_out, // SCL pull-low enable
	output logic sda_out, // SDA drive value (always 0)
	output logic sda_oe_out, // SDA pull-low enable
	output logic cmd_ready_out, // Command accepted this cycle
	output logic busy_out, // Bus owned by this master
	output logic bit_done_out, // Pulse: bit completed, SDA sampled
	output logic sda_sample_out, // Sampled SDA at SCL high
	output logic timeout_out // Sticky clock-low timeout flag
);
	typedef struct packed {
		smbtg_pkg::smbtg_state_t state;
		logic [smbtg_pkg::OVF_CNT_W-1:0] cnt;
		logic scl_low;
		logic sda_low;
		logic bit_done;
		logic sda_sample;
		logic [31:0] low_cnt;
		logic timeout;
	} smbtg_top_t;
	smbtg_top_t st_r;
	smbtg_top_t st_nxt;
	logic scl_s;
	logic sda_s;
	logic tick;
	logic cmd_take;
	logic [smbtg_pkg::OVF_CNT_W-1:0] cnt_inc;

	// Pins pass two flops before use
	smbtg_sync u_scl_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.rst_val_in(1'b1),
		.d_in(scl_in),
		.q_out(scl_s)
	);
	smbtg_sync u_sda_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.rst_val_in(1'b1),
		.d_in(sda_in),
		.q_out(sda_s)
	);

	assign tick = ovf_strobe_in;
	assign cnt_inc = st_r.cnt + 2'h1;
	// Command taken only at the end of a high phase; the SCL level gates it
	// too, so a tick that lands in a stretch never drops an accepted command
	assign cmd_take = (st_r.state == smbtg_pkg::SMBTG_HIGH) && tick && scl_s && cmd_valid_in
		&& (cnt_inc == 2'(smbtg_pkg::HIGH_OVF));

	// Phase sequencer; counts restart at each event so every interval is whole
	always_comb begin
		st_nxt = st_r;
		st_nxt.bit_done = 1'b0;
		case (st_r.state)
			smbtg_pkg::SMBTG_IDLE: begin
				st_nxt.scl_low = 1'b0;
				st_nxt.sda_low = 1'b0;
				st_nxt.cnt = '0;
				// START waits for a strobe so its hold is a whole period
				if (start_in && tick) begin
					st_nxt.sda_low = 1'b1; // START: SDA falls with SCL high
					st_nxt.state = smbtg_pkg::SMBTG_START_HOLD;
				end
			end
			smbtg_pkg::SMBTG_START_HOLD: begin
				if (tick) begin
					st_nxt.scl_low = 1'b1;
					st_nxt.state = smbtg_pkg::SMBTG_LOW;
				end
			end
			smbtg_pkg::SMBTG_LOW: begin
				if (tick) begin
					st_nxt.scl_low = 1'b0;
					st_nxt.cnt = '0;
					st_nxt.state = smbtg_pkg::SMBTG_HIGH;
				end else begin
					st_nxt.sda_low = ~sda_bit_in;
				end
			end
			smbtg_pkg::SMBTG_HIGH: begin
				// Wait while a slave stretches SCL low
				if (tick && scl_s) begin
					st_nxt.cnt = cnt_inc;
					if (cnt_inc == 2'(smbtg_pkg::HIGH_OVF)) begin
						st_nxt.bit_done = 1'b1;
						st_nxt.sda_sample = sda_s;
						st_nxt.cnt = '0;
						st_nxt.scl_low = 1'b1;
						st_nxt.state = smbtg_pkg::SMBTG_LOW;
						if (cmd_take && cmd_in == smbtg_pkg::SMBTG_CMD_RESTART) begin
							st_nxt.sda_low = 1'b0; // release for setup
							st_nxt.state = smbtg_pkg::SMBTG_RS_SETUP;
						end else if (cmd_take && cmd_in == smbtg_pkg::SMBTG_CMD_STOP) begin
							st_nxt.sda_low = 1'b1; // hold low for setup
							st_nxt.state = smbtg_pkg::SMBTG_STOP_SETUP;
						end
					end
				end
			end
			smbtg_pkg::SMBTG_RS_SETUP, smbtg_pkg::SMBTG_STOP_SETUP: begin
				// One low period, then SCL released for the setup count
				if (st_r.scl_low) begin
					if (tick) begin
						st_nxt.scl_low = 1'b0;
					end
				end else if (tick && scl_s) begin
					st_nxt.cnt = cnt_inc;
					if (st_r.state == smbtg_pkg::SMBTG_RS_SETUP
						&& cnt_inc == 2'(smbtg_pkg::RESTART_SETUP_OVF)) begin
						st_nxt.cnt = '0;
						st_nxt.sda_low = 1'b1; // repeated START
						st_nxt.state = smbtg_pkg::SMBTG_START_HOLD;
					end else if (st_r.state == smbtg_pkg::SMBTG_STOP_SETUP
						&& cnt_inc == 2'(smbtg_pkg::STOP_SETUP_OVF)) begin
						st_nxt.cnt = '0;
						st_nxt.sda_low = 1'b0; // STOP
						st_nxt.state = smbtg_pkg::SMBTG_BUS_FREE;
					end
				end
			end
			smbtg_pkg::SMBTG_BUS_FREE: begin
				if (tick) begin
					st_nxt.cnt = cnt_inc;
					if (cnt_inc == 2'(smbtg_pkg::STOP_GAP_OVF)) begin
						st_nxt.cnt = '0;
						st_nxt.state = smbtg_pkg::SMBTG_IDLE;
					end
				end
			end
			default: begin
				st_nxt.state = smbtg_pkg::SMBTG_IDLE;
			end
		endcase
		// Clock-low watchdog; counter saturates, flag is sticky until reset
		if (scl_s) begin
			st_nxt.low_cnt = '0;
		end else if (st_r.low_cnt < 32'(TIMEOUT_CYC)) begin
			st_nxt.low_cnt = st_r.low_cnt + 32'h0000_0001;
		end
		if (st_r.low_cnt >= 32'(TIMEOUT_CYC)) begin
			st_nxt.timeout = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '{state: smbtg_pkg::SMBTG_IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_out = st_r.scl_low;
	assign sda_oe_out = st_r.sda_low;
	assign cmd_ready_out = cmd_take;
	assign busy_out = (st_r.state != smbtg_pkg::SMBTG_IDLE);
	assign bit_done_out = st_r.bit_done;
	assign sda_sample_out = st_r.sda_sample;
	assign timeout_out = st_r.timeout;

	// Checks
	a_low_one_tick: assert property (@(posedge clk_in) disable iff (rst_in)
		(st_r.state == smbtg_pkg::SMBTG_LOW && tick) |=> !st_r.scl_low)
		else $error("scl low phase not one overflow");
	a_high_two_ticks: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(st_r.bit_done) |-> $past(st_r.cnt) == 2'(smbtg_pkg::HIGH_OVF - 1))
		else $error("scl high phase not two overflows");
	a_free_gap: assert property (@(posedge clk_in) disable iff (rst_in)
		(st_r.state == smbtg_pkg::SMBTG_BUS_FREE && !tick) |=>
		st_r.state == smbtg_pkg::SMBTG_BUS_FREE)
		else $error("bus free left without overflow");
	a_start_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		(st_r.state == smbtg_pkg::SMBTG_START_HOLD) |-> !st_r.scl_low)
		else $error("scl low during start hold");
	a_restart_setup: assert property (@(posedge clk_in) disable iff (rst_in)
		(st_r.state == smbtg_pkg::SMBTG_RS_SETUP) |-> !st_r.sda_low)
		else $error("sda low during restart setup");
	a_stop_setup: assert property (@(posedge clk_in) disable iff (rst_in)
		$fell(st_r.sda_low) && $past(st_r.state) == smbtg_pkg::SMBTG_STOP_SETUP
		|-> $past(st_r.cnt) == 2'(smbtg_pkg::STOP_SETUP_OVF - 1))
		else $error("stop released early");
	a_timeout_flag: assert property (@(posedge clk_in) disable iff (rst_in)
		(st_r.low_cnt >= 32'(TIMEOUT_CYC)) |=> st_r.timeout)
		else $error("timeout not flagged");
	a_tick_step: assert property (@(posedge clk_in) disable iff (rst_in)
		(!tick && st_r.state != smbtg_pkg::SMBTG_IDLE) |=> $stable(st_r.scl_low))
		else $error("scl moved without overflow");
	// A START launched between strobes would leave a partial hold period
	a_start_on_tick: assert property (@(posedge clk_in) disable iff (rst_in)
		($rose(st_r.sda_low) && st_r.state == smbtg_pkg::SMBTG_START_HOLD) |-> $past(tick))
		else $error("start not aligned to overflow");
	a_cmd_taken: assert property (@(posedge clk_in) disable iff (rst_in)
		cmd_take |=> st_r.bit_done)
		else $error("accepted command lost");
	c_start: cover property (@(posedge clk_in) st_r.state == smbtg_pkg::SMBTG_START_HOLD);
	c_restart: cover property (@(posedge clk_in) st_r.state == smbtg_pkg::SMBTG_RS_SETUP);
	c_stop: cover property (@(posedge clk_in) st_r.state == smbtg_pkg::SMBTG_BUS_FREE);
	c_timeout: cover property (@(posedge clk_in) st_r.timeout);
endmodule : smbtg_top

// ==== smbtg_pkg.sv ====
// Package for the SMBus master bus-phase timing generator.
// Assumes a 10 MHz system clock; bus intervals count overflow strobes.
package smbtg_pkg;
	// System clock period in ns
	localparam int CLK_PERIOD_NS = 100;
	// Overflow periods per bus interval
	localparam int LOW_OVF = 1;
	localparam int HIGH_OVF = 2;
	localparam int START_HOLD_OVF = 1;
	localparam int RESTART_SETUP_OVF = 2;
	localparam int STOP_SETUP_OVF = 2;
	localparam int STOP_GAP_OVF = 2;
	// Clock-low timeout in ms, and its cycle count (rounded down)
	localparam int SCL_LOW_TIMEOUT_MS = 25;
	localparam int SCL_LOW_TIMEOUT_CYC = SCL_LOW_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int OVF_CNT_W = 2;
	// Bus phase states, one-hot
	typedef enum logic [6:0] {
		SMBTG_IDLE = 7'h01,
		SMBTG_START_HOLD = 7'h02,
		SMBTG_LOW = 7'h04,
		SMBTG_HIGH = 7'h08,
		SMBTG_RS_SETUP = 7'h10,
		SMBTG_STOP_SETUP = 7'h20,
		SMBTG_BUS_FREE = 7'h40
	} smbtg_state_t;
	// Bus commands
	typedef enum logic [1:0] {
		SMBTG_CMD_BIT = 2'h0,
		SMBTG_CMD_RESTART = 2'h1,
		SMBTG_CMD_STOP = 2'h2
	} smbtg_cmd_t;
endpackage : smbtg_pkg

// ==== smbtg_sync.sv ====
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to clk_in.
`timescale 1ns/1ns
module smbtg_sync (
	input wire logic clk_in, // System clock
	input wire logic rst_in, // Async reset, active high
	input wire logic rst_val_in, // Unused-safe marker, tie per level
	input wire logic d_in, // Asynchronous level
	output logic q_out // Synchronised level
);
	typedef struct packed {
		logic s1;
		logic s2;
	} smbtg_sync_t;
	smbtg_sync_t st_r;
	smbtg_sync_t st_nxt;

	// First flop feeds only the second
	always_comb begin
		st_nxt.s1 = d_in;
		st_nxt.s2 = st_r.s1;
	end

	// Reset to idle-high bus level
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= 2'h3;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q_out = st_r.s2 & (rst_val_in | 1'b1);
endmodule : smbtg_sync

// ==== smbtg_slave_model.sv ====
// Slave stand-in on SCL: stretches each release, or stalls the line.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ns
module smbtg_slave_model (
	input wire logic clk_in, // System clock
	input wire logic rst_in, // Async reset, active high
	input wire logic m_scl_oe_in, // Master SCL pull-low
	input wire logic [3:0] stretch_in, // Stretch length, cycles
	input wire logic stall_in, // Hold SCL low
	output logic scl_oe_out // Slave SCL pull-low
);
	logic prev_r;
	logic [3:0] cnt_r;
	// Stretch starts the cycle the master lets go, so no glitch high
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prev_r <= 1'h0;
			cnt_r <= 4'h0;
		end else begin
			prev_r <= m_scl_oe_in;
			if (prev_r && !m_scl_oe_in)
				cnt_r <= stretch_in;
			else if (cnt_r != 4'h0)
				cnt_r <= cnt_r - 4'h1;
		end
	end
	assign scl_oe_out = stall_in || (cnt_r != 4'h0) || (prev_r && !m_scl_oe_in);
endmodule : smbtg_slave_model

// ==== smbtg_top_tb.sv ====
// Bench for the bus-phase timing generator with a stretching slave.
// Assumes the slave model is compiled first; SCL and SDA pull up.
`timescale 1ns/1ns
module smbtg_top_tb;
	typedef struct {int n1; int rs; int n2; int st; logic b; int rises;} smbtg_row_t;
	logic clk = 1'h0, rst = 1'h1, ovf = 1'h0, start = 1'h0, cv = 1'h0;
	logic dbit = 1'h0, stall = 1'h0, pscl = 1'h1, psda = 1'h1;
	logic xfer = 1'h0, fresh = 1'h0, stopped = 1'h0;
	logic [1:0] cmd = 2'h0;
	logic [3:0] stretch = 4'h0, div = 4'h0;
	logic m_scl, m_sda, s_scl, scl, sda, rdy, busy, done, samp, tmo, scl_dv, sda_dv;
	int miscompares = 0, checked = 0, nscl = 0, nsda = 0, rises = 0, i;
	// Bits, restart, bits after it, stretch, data bit, SCL rises expected
	smbtg_row_t rows[4] = '{'{1, 0, 0, 0, 1'h1, 2}, '{3, 0, 0, 3, 1'h0, 4},
		'{2, 1, 1, 0, 1'h1, 5}, '{1, 1, 2, 3, 1'h0, 5}};
	// Open-drain wires: pull-ups win when nobody pulls low
	assign scl = !(m_scl || s_scl);
	assign sda = !m_sda;
	initial begin
		forever #50 clk = !clk;
	end
	smbtg_top #(.TIMEOUT_CYC(50)) i_dut (.clk_in(clk), .rst_in(rst), .ovf_strobe_in(ovf),
		.start_in(start), .cmd_valid_in(cv), .cmd_in(cmd), .sda_bit_in(dbit), .scl_in(scl),
		.sda_in(sda), .scl_out(scl_dv), .scl_oe_out(m_scl), .sda_out(sda_dv), .sda_oe_out(m_sda),
		.cmd_ready_out(rdy), .busy_out(busy), .bit_done_out(done), .sda_sample_out(samp),
		.timeout_out(tmo));
	smbtg_slave_model i_slave (.clk_in(clk), .rst_in(rst), .m_scl_oe_in(m_scl),
		.stretch_in(stretch), .stall_in(stall), .scl_oe_out(s_scl));
	// One strobe per 16 cycles keeps the bus at 208 kHz
	always @(posedge clk) begin
		div <= div + 4'h1;
		ovf <= (div == 4'hf);
	end
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (!ok) begin
			miscompares++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk
	// Strobes per wire phase, judged at SCL edges during a transfer and at SDA edges while SCL is high
	always @(posedge clk) begin
		if (scl != pscl && xfer) begin
			if (scl) begin
				chk(nscl === 1, "low phase");
				rises++;
			end else if (fresh) chk(nsda === 1, "start hold");
			else chk(nscl === 2, "high phase");
		end
		if (scl != pscl && !scl)
			fresh <= 1'h0;
		if (sda != psda && scl && pscl) begin
			if (!sda && xfer) chk(nscl === 2, "restart setup");
			if (!sda && !xfer && stopped) chk(nsda >= 2, "bus free");
			if (sda && xfer) chk(nscl === 2, "stop setup");
			stopped <= stopped | sda;
			xfer <= !sda;
			fresh <= !sda;
		end
		nscl <= (scl != pscl ? 0 : nscl) + ovf;
		nsda <= (sda != psda ? 0 : nsda) + ovf;
		pscl <= scl;
		psda <= sda;
	end
	// Offer a command after n bits; the pause skips a trailing done pulse
	task automatic after_bits(input int n, input logic [1:0] c, input logic b);
		int k;
		for (k = 1; k < n; k++) begin
			do @(posedge clk); while (done !== 1'h1);
			chk(samp === b, "sampled bit");
		end
		cv <= 1'h1;
		cmd <= c;
		do @(posedge clk); while (rdy !== 1'h1);
		cv <= 1'h0;
		repeat (2) @(posedge clk);
	endtask : after_bits
	// Start is held from the previous row's free time until a strobe in idle
	task automatic xfer_row(input smbtg_row_t r);
		stretch <= r.st[3:0];
		dbit <= r.b;
		start <= 1'h1;
		do @(posedge clk); while (m_sda !== 1'h1);
		start <= 1'h0;
		rises = 0;
		if (r.rs != 0) begin
			after_bits(r.n1, smbtg_pkg::SMBTG_CMD_RESTART, r.b);
			after_bits(r.n2, smbtg_pkg::SMBTG_CMD_STOP, r.b);
		end else after_bits(r.n1, smbtg_pkg::SMBTG_CMD_STOP, r.b);
		do @(posedge clk); while (xfer);
		chk(rises === r.rises, "scl cycles");
		chk({scl_dv, sda_dv} === 2'h0, "open drain value");
	endtask : xfer_row
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// Whole run is near 1100 cycles; the margin only catches hangs
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_sim();
	end
	// Reset, rows, then stall timeout and a second reset
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		chk({m_scl, m_sda, busy, tmo, scl_dv, sda_dv} === 6'h00, "reset outputs");
		$display("reset test done");
		for (i = 0; i < 4; i++) begin
			xfer_row(rows[i]);
			$display("row %0d done", i);
		end
		do @(posedge clk); while (busy !== 1'h0);
		stall <= 1'h1;
		repeat (45) @(posedge clk);
		chk(tmo === 1'h0, "early timeout");
		repeat (15) @(posedge clk);
		chk(tmo === 1'h1, "no timeout");
		stall <= 1'h0;
		repeat (5) @(posedge clk);
		chk(tmo === 1'h1, "timeout not sticky");
		$display("timeout test done");
		rst <= 1'h1;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		chk({tmo, busy, m_scl, m_sda} === 4'h0, "second reset");
		$display("second reset test done");
		end_sim();
	end
endmodule : smbtg_top_tb
